// ### hw/tcc_consts.svh
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// register addresses
`define TCC_ADDR_STATUS   16'h0020
`define TCC_ADDR_CNT_HI   16'h0022
`define TCC_ADDR_CNT_LO   16'h0023
`define TCC_ADDR_MOD_HI   16'h0024
`define TCC_ADDR_MOD_LO   16'h0025
`define TCC_ADDR_CH0      16'h0026
`define TCC_CH_STRIDE     16'h0003
`define TCC_NUM_CH        6

// status/control field positions
`define TCC_BIT_OVF       7
`define TCC_BIT_OVF_IE    6
`define TCC_BIT_HALT      5
`define TCC_BIT_CNT_RST   4
`define TCC_PSC_MSB       2
`define TCC_PSC_LSB       0

// channel status field positions
`define TCC_BIT_CH_FLAG   7
`define TCC_BIT_CH_IE     6

// reset values
`define TCC_RST_HALT      1'b1
`define TCC_RST_PSC       3'h0
`define TCC_RST_MOD       16'hffff
`define TCC_RST_CNT       16'h0000

// prescaler width
`define TCC_PSC_W         6

`endif

// ### hw/tcc_pkg.sv
`default_nettype none

package tcc_pkg;

    typedef enum logic [2:0] {
        TCC_DIV1  = 3'h0,
        TCC_DIV2  = 3'h1,
        TCC_DIV4  = 3'h2,
        TCC_DIV8  = 3'h3,
        TCC_DIV16 = 3'h4,
        TCC_DIV32 = 3'h5,
        TCC_DIV64 = 3'h6,
        TCC_EXT   = 3'h7
    } tcc_clk_src_e;

    typedef logic [15:0] tcc_cnt_t;

endpackage : tcc_pkg

`default_nettype wire

// ### hw/tcc_core.sv
// Behaviour
// R1: overflow flag set on modulo rollover to zero
// R2: overflow request when flag and enable set
// R3: channel flag on event; request gated by enable
// R4: counts in wait; requests wake processor
// R5: no register access during wait mode
// R6: stop mode freezes everything, state kept
// R7: counter frozen during break
// R8: break clears status only when enabled
// R9: armed clear held through break, completes after
// R10: code 111 clocks from external pin input
// R11: codes 000-110 divide bus clock 1..64
// R12: overflow flag read-then-write-0 clear sequence
// R13: halt bit stops counter; reset sets it
// R14: halt suppresses input captures
// R15: counter reset bit clears counter, prescaler
// R16: halt plus counter reset stops at zero
// R17: high read latches low byte once
// R18: latched low byte survives break end
// R19: software keeps counter running before wait
// R20: counter bytes read-only, cleared by resets
// R21: counter restarts at zero after modulo
// R22: modulo high write suppresses overflow until low
// R23: modulo resets to all ones
// R24: counter increments on each timer tick
`include "tcc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tcc_core (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // cpu register bus
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    // system mode inputs
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    input  wire logic        break_active,
    input  wire logic        break_clear_enable,
    // external timer clock pin
    input  wire logic        external_timer_clock_pin,
    output logic             ext_pin_force_input,
    // channel events
    input  wire logic [5:0]  ch_is_capture,
    input  wire logic [5:0]  ch_capture_evt,
    input  wire logic [5:0]  ch_compare_evt,
    // counter value to channels
    output logic      [15:0] count_value,
    // interrupt requests
    output logic             ovf_irq,
    output logic      [5:0]  ch_irq,
    output logic             wake_req
);

    function automatic logic [`TCC_PSC_W-1:0] psc_mask(input logic [2:0] sel);
        psc_mask = `TCC_PSC_W'((7'h01 << sel) - 7'h01);
    endfunction : psc_mask
    function automatic logic [15:0] ch_addr(input int idx);
        ch_addr = 16'(`TCC_ADDR_CH0 + `TCC_CH_STRIDE * idx);
    endfunction : ch_addr
    logic                  run;
    logic                  acc_ok;
    logic                  brk_lock;
    logic                  rd_stat;
    logic                  wr_stat;
    logic                  rd_cnt_hi;
    logic                  rd_cnt_lo;
    logic                  wr_mod_hi;
    logic                  wr_mod_lo;
    logic                  cnt_rst_wr;
    logic                  tick;
    logic                  cnt_go;
    logic                  ovf_evt;
    logic [5:0]            rd_ch;
    logic [5:0]            wr_ch;
    logic [5:0]            ch_evt;
    logic [7:0]            nxt_rdata;
    logic                  ovf_flag_ff;
    logic                  ovf_arm_ff;
    logic                  ovf_ie_ff;
    logic                  halt_ff;
    tcc_pkg::tcc_clk_src_e psc_sel_ff;
    logic [`TCC_PSC_W-1:0] psc_ff;
    tcc_pkg::tcc_cnt_t     cnt_ff;
    tcc_pkg::tcc_cnt_t     mod_ff;
    logic                  mod_hi_pend_ff;
    logic [7:0]            lo_latch_ff;
    logic                  lo_held_ff;
    logic [5:0]            ch_flag_ff;
    logic [5:0]            ch_arm_ff;
    logic [5:0]            ch_ie_ff;
    logic                  ext_s1_ff;
    logic                  ext_s2_ff;
    logic                  ext_s3_ff;
    logic [7:0]            rdata_ff;
    // global qualifiers
    assign run      = ce & ~stop_mode;                          // [R6]
    assign acc_ok   = run & ~wait_mode;                         // [R5]
    assign brk_lock = break_active & ~break_clear_enable;       // [R8]
    // address decode
    assign rd_stat    = acc_ok & bus_rd & (bus_addr == `TCC_ADDR_STATUS);
    assign wr_stat    = acc_ok & bus_wr & (bus_addr == `TCC_ADDR_STATUS);
    assign rd_cnt_hi  = acc_ok & bus_rd & (bus_addr == `TCC_ADDR_CNT_HI);
    assign rd_cnt_lo  = acc_ok & bus_rd & (bus_addr == `TCC_ADDR_CNT_LO);
    assign wr_mod_hi  = acc_ok & bus_wr & (bus_addr == `TCC_ADDR_MOD_HI);
    assign wr_mod_lo  = acc_ok & bus_wr & (bus_addr == `TCC_ADDR_MOD_LO);
    assign cnt_rst_wr = wr_stat & bus_wdata[`TCC_BIT_CNT_RST];  // [R15]

    always_comb begin
        for (int i = 0; i < `TCC_NUM_CH; i++) begin
            rd_ch[i] = acc_ok & bus_rd & (bus_addr == ch_addr(i));
            wr_ch[i] = acc_ok & bus_wr & (bus_addr == ch_addr(i));
        end
    end

    // external clock pin synchroniser and edge detect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else if (run) begin
            ext_s1_ff <= external_timer_clock_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end
    // pin is an input whenever it clocks the counter
    assign ext_pin_force_input = (psc_sel_ff == tcc_pkg::TCC_EXT); // [R10]

    // prescaler, cleared with the counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            psc_ff <= '0;
        end else if (run) begin
            if (cnt_rst_wr) begin
                psc_ff <= '0;                                   // [R15]
            end else if (!halt_ff && !break_active) begin
                psc_ff <= psc_ff + `TCC_PSC_W'(1);
            end
        end
    end

    // timer tick from the selected source
    always_comb begin
        if (psc_sel_ff == tcc_pkg::TCC_EXT) begin
            tick = ext_s2_ff & ~ext_s3_ff;                      // [R10]
        end else begin
            tick = (psc_ff & psc_mask(psc_sel_ff)) == psc_mask(psc_sel_ff); // [R11]
        end
    end

    assign cnt_go  = run & ~halt_ff & ~break_active & ~cnt_rst_wr & tick; // [R7] [R13] [R24]
    assign ovf_evt = cnt_go & (cnt_ff == mod_ff) & ~mod_hi_pend_ff; // [R1] [R22]
    // counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= `TCC_RST_CNT;                             // [R20]
        end else if (run) begin
            if (cnt_rst_wr) begin
                cnt_ff <= `TCC_RST_CNT;                         // [R15] [R16] [R20]
            end else if (cnt_go) begin
                if (cnt_ff == mod_ff) begin
                    cnt_ff <= `TCC_RST_CNT;                     // [R21]
                end else begin
                    cnt_ff <= cnt_ff + 16'h0001;                // [R24]
                end
            end
        end
    end
    assign count_value = cnt_ff;

    // control fields of the status register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_ie_ff  <= 1'b0;
            halt_ff    <= `TCC_RST_HALT;                        // [R13]
            psc_sel_ff <= tcc_pkg::tcc_clk_src_e'(`TCC_RST_PSC); // [R11]
        end else if (wr_stat) begin
            ovf_ie_ff  <= bus_wdata[`TCC_BIT_OVF_IE];
            halt_ff    <= bus_wdata[`TCC_BIT_HALT];             // [R13] [R16]
            psc_sel_ff <= tcc_pkg::tcc_clk_src_e'(bus_wdata[`TCC_PSC_MSB:`TCC_PSC_LSB]);
        end
    end

    // overflow flag with two-step clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_arm_ff <= 1'b0;
        end else if (run) begin
            if (ovf_evt) begin
                ovf_arm_ff <= 1'b0;                             // [R12]
            end else if (brk_lock) begin
                ovf_arm_ff <= ovf_arm_ff;                       // [R9]
            end else if (rd_stat && ovf_flag_ff) begin
                ovf_arm_ff <= 1'b1;                             // [R12]
            end else if (wr_stat) begin
                ovf_arm_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_flag_ff <= 1'b0;                                // [R12]
        end else if (run) begin
            if (ovf_evt) begin
                ovf_flag_ff <= 1'b1;                            // [R1]
            end else if (wr_stat && !bus_wdata[`TCC_BIT_OVF] && ovf_arm_ff && !brk_lock) begin
                ovf_flag_ff <= 1'b0;                            // [R8] [R9] [R12]
            end
        end
    end

    // modulo value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mod_ff         <= `TCC_RST_MOD;                     // [R23]
            mod_hi_pend_ff <= 1'b0;
        end else begin
            if (wr_mod_hi) begin
                mod_ff[15:8]   <= bus_wdata;
                mod_hi_pend_ff <= 1'b1;                         // [R22]
            end else if (wr_mod_lo) begin
                mod_ff[7:0]    <= bus_wdata;
                mod_hi_pend_ff <= 1'b0;                         // [R22]
            end
        end
    end

    // low-byte holding buffer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_latch_ff <= 8'h00;
            lo_held_ff  <= 1'b0;
        end else begin
            if (rd_cnt_lo) begin
                lo_held_ff <= 1'b0;                             // [R17]
            end else if (rd_cnt_hi && !lo_held_ff) begin
                lo_latch_ff <= cnt_ff[7:0];                     // [R17]
                lo_held_ff  <= 1'b1;                            // [R18]
            end
        end
    end

    // channel events; captures blocked while halted
    always_comb begin
        for (int i = 0; i < `TCC_NUM_CH; i++) begin
            ch_evt[i] = run & ((ch_is_capture[i] & ch_capture_evt[i] & ~halt_ff) // [R14]
                      | (~ch_is_capture[i] & ch_compare_evt[i]));
        end
    end

    // channel enables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch_ie_ff <= 6'h00;
        end else begin
            for (int i = 0; i < `TCC_NUM_CH; i++) begin
                if (wr_ch[i]) begin
                    ch_ie_ff[i] <= bus_wdata[`TCC_BIT_CH_IE];
                end
            end
        end
    end

    // channel flags with two-step clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch_flag_ff <= 6'h00;
            ch_arm_ff  <= 6'h00;
        end else if (run) begin
            for (int i = 0; i < `TCC_NUM_CH; i++) begin
                if (ch_evt[i]) begin
                    ch_flag_ff[i] <= 1'b1;                      // [R3]
                    ch_arm_ff[i]  <= 1'b0;
                end else if (!brk_lock) begin                   // [R8] [R9]
                    if (rd_ch[i] && ch_flag_ff[i]) begin
                        ch_arm_ff[i] <= 1'b1;
                    end else if (wr_ch[i]) begin
                        ch_arm_ff[i] <= 1'b0;
                        if (!bus_wdata[`TCC_BIT_CH_FLAG] && ch_arm_ff[i]) begin
                            ch_flag_ff[i] <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // read data mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (bus_addr == `TCC_ADDR_STATUS) begin
            nxt_rdata[`TCC_BIT_OVF]    = ovf_flag_ff;
            nxt_rdata[`TCC_BIT_OVF_IE] = ovf_ie_ff;
            nxt_rdata[`TCC_BIT_HALT]   = halt_ff;               // counter reset reads 0 [R15]
            nxt_rdata[`TCC_PSC_MSB:`TCC_PSC_LSB] = psc_sel_ff;
        end else if (bus_addr == `TCC_ADDR_CNT_HI) begin
            nxt_rdata = cnt_ff[15:8];                           // [R20]
        end else if (bus_addr == `TCC_ADDR_CNT_LO) begin
            nxt_rdata = lo_held_ff ? lo_latch_ff : cnt_ff[7:0]; // [R17]
        end else if (bus_addr == `TCC_ADDR_MOD_HI) begin
            nxt_rdata = mod_ff[15:8];
        end else if (bus_addr == `TCC_ADDR_MOD_LO) begin
            nxt_rdata = mod_ff[7:0];
        end else begin
            for (int i = 0; i < `TCC_NUM_CH; i++) begin
                if (bus_addr == ch_addr(i)) begin
                    nxt_rdata[`TCC_BIT_CH_FLAG] = ch_flag_ff[i];
                    nxt_rdata[`TCC_BIT_CH_IE]   = ch_ie_ff[i];
                end
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (acc_ok && bus_rd) begin
            rdata_ff <= nxt_rdata;                              // [R5]
        end
    end

    assign bus_rdata = rdata_ff;
    // interrupt requests and wake
    assign ovf_irq  = ovf_flag_ff & ovf_ie_ff;                  // [R2]
    assign ch_irq   = ch_flag_ff & ch_ie_ff;                    // [R3]
    assign wake_req = wait_mode & (ovf_irq | (|ch_irq));        // [R4]

endmodule : tcc_core

`default_nettype wire

// ### bench/tcc_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_core_properties (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    // register bus
    input wire logic [15:0] bus_addr,
    input wire logic        bus_rd,
    input wire logic        bus_wr,
    input wire logic [7:0]  bus_wdata,
    input wire logic [7:0]  bus_rdata,
    // modes and outputs
    input wire logic        wait_mode,
    input wire logic        stop_mode,
    input wire logic        break_active,
    input wire logic        ext_pin_force_input,
    input wire logic [15:0] count_value,
    input wire logic        ovf_irq,
    input wire logic [5:0]  ch_irq,
    input wire logic        wake_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic acc;
    assign acc = ce && !wait_mode && !stop_mode;
    // accepted status write with all bits of m set
    sequence s_stat_wr(logic [7:0] m);
        acc && bus_wr && bus_addr == 16'h0020 && (bus_wdata & m) == m;
    endsequence
    chk_wake_level: assert property (wake_req == (wait_mode && (ovf_irq || |ch_irq)))
        else $error("wake request mismatch");
    chk_stop_frozen: assert property (stop_mode |=> $stable(count_value))
        else $error("counter moved in stop");
    chk_break_frozen: assert property (break_active && !bus_wr |=> $stable(count_value))
        else $error("counter moved in break");
    chk_count_step: assert property (!$stable(count_value) |->
        count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000)
        else $error("counter step wrong");
    chk_rdata_cause: assert property (!$stable(bus_rdata) |-> $past(acc && bus_rd))
        else $error("read data changed without read");
    chk_ext_select: assert property (s_stat_wr(8'h07) |=> ext_pin_force_input)
        else $error("pin not forced input");
    chk_rst_zero: assert property (s_stat_wr(8'h10) |=> count_value == 16'h0000)
        else $error("counter reset missed");
    chk_halt_rst: assert property (s_stat_wr(8'h30) |=> (count_value == 16'h0000) [*3])
        else $error("halted counter not at zero");
    chk_ovf_rise: assert property ($rose(ovf_irq) && !$past(bus_wr) |-> count_value == 16'h0000)
        else $error("overflow not at rollover");
endmodule : tcc_core_properties
`default_nettype wire

// ### bench/tcc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model (
    // register bus
    input  wire logic        clk,
    input  wire logic [7:0]  bus_rdata,
    output logic      [15:0] bus_addr,
    output logic             bus_rd,
    output logic             bus_wr,
    output logic      [7:0]  bus_wdata
);
    initial begin
        bus_addr = 16'h0000;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_wdata = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge clk);
        #2;
        bus_wr = 1'b0;
        bus_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        #2;
        bus_addr = a;
        bus_rd = 1'b1;
        @(posedge clk);
        #2;
        bus_rd = 1'b0;
        d = bus_rdata;
    endtask : rd
    // read with flag set, then write back with flag bit low
    task automatic clr(input logic [15:0] a, input logic [7:0] keep);
        logic [7:0] d;
        rd(a, d);
        wr(a, keep);
    endtask : clr
endmodule : tcc_cpu_model
`default_nettype wire

// ### bench/tcc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_core_tb;
    localparam logic [15:0] st = 16'h0020;
    logic clk = 0, rst_n = 0, ce = 1, wait_mode = 0, stop_mode = 0, brk = 0, bce = 0;
    logic pin = 0, rd, wr, ext, ovf_irq, wake;
    logic [15:0] addr, cnt, v;
    logic [7:0]  wdata, rdata, d;
    logic [5:0]  cap_mode = 0, cap = 0, cmp = 0, ch_irq;
    int errors = 0, n_compared = 0;
    logic [15:0] ra [7] = '{16'h0020, 16'h0021, 16'h0022, 16'h0023, 16'h0024, 16'h0025, 16'h0026};
    logic [7:0]  re [7] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
    always #12.5 clk = ~clk;
    tcc_core u_dut (.clk, .rst_n, .ce, .bus_addr(addr), .bus_rd(rd), .bus_wr(wr),
        .bus_wdata(wdata), .bus_rdata(rdata), .wait_mode, .stop_mode, .break_active(brk),
        .break_clear_enable(bce), .external_timer_clock_pin(pin), .ext_pin_force_input(ext),
        .ch_is_capture(cap_mode), .ch_capture_evt(cap), .ch_compare_evt(cmp),
        .count_value(cnt), .ovf_irq, .ch_irq, .wake_req(wake));
    tcc_cpu_model u_cpu (.clk, .bus_rdata(rdata), .bus_addr(addr), .bus_rd(rd), .bus_wr(wr),
        .bus_wdata(wdata));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] x;
        u_cpu.rd(a, x);
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, x});
    endtask : rc
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tk
    task automatic ev(input logic c, input int i);
        if (c) cap = 6'h01 << i;
        else cmp = 6'h01 << i;
        tk(1);
        cap = 0;
        cmp = 0;
    endtask : ev
    task automatic conclude();
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end
    initial begin
        tk(20);
        rst_n = 1;
        for (int i = 0; i < 7; i++) rc(ra[i], re[i]);
        tk(10);
        chk("halted", 0, cnt);
        for (int c = 0; c < 7; c++) begin
            u_cpu.wr(st, 8'h30 | c);
            u_cpu.wr(st, 8'(c));
            v = cnt;
            for (int k = 0; k < 200 && cnt === v; k++) tk(1);
            v = cnt;
            tk(4 << c);
            chk("div", v + 16'h0004, cnt);
        end
        u_cpu.wr(st, 8'h37);
        u_cpu.wr(st, 8'h07);
        chk("ext", 1, ext);
        repeat (3) begin
            pin = 1;
            tk(4);
            pin = 0;
            tk(4);
        end
        chk("ext cnt", 3, cnt);
        u_cpu.wr(st, 8'h10);
        chk("rst", 0, cnt);
        rc(st, 8'h00);
        tk(37);
        u_cpu.wr(st, 8'h20);
        v = cnt;
        rc(16'h0022, v[15:8]);
        u_cpu.wr(st, 8'h30);
        chk("halt rst", 0, cnt);
        rc(16'h0022, 8'h00);
        rc(16'h0023, v[7:0]);
        rc(16'h0023, 8'h00);
        u_cpu.wr(st, 8'h00);
        tk(20);
        brk = 1;
        tk(2);
        v = cnt;
        tk(20);
        chk("brk", v, cnt);
        rc(16'h0022, v[15:8]);
        brk = 0;
        tk(30);
        rc(16'h0023, v[7:0]);
        u_cpu.wr(st, 8'h30);
        u_cpu.wr(16'h0024, 8'h00);
        u_cpu.wr(16'h0025, 8'h0f);
        u_cpu.wr(st, 8'h00);
        tk(40);
        rc(st, 8'h80);
        chk("wrap", 0, cnt & 16'hfff0);
        u_cpu.wr(st, 8'h20);
        u_cpu.clr(st, 8'h20);
        rc(st, 8'h20);
        u_cpu.wr(st, 8'ha0);
        rc(st, 8'h20);
        u_cpu.wr(st, 8'h30);
        u_cpu.wr(16'h0024, 8'h00);
        u_cpu.wr(st, 8'h00);
        tk(40);
        rc(st, 8'h00);
        u_cpu.wr(st, 8'h30);
        u_cpu.wr(16'h0025, 8'h00);
        u_cpu.wr(st, 8'h00);
        tk(3);
        rc(st, 8'h80);
        u_cpu.clr(st, 8'h00);
        rc(st, 8'h80);
        chk("irq off", 0, ovf_irq);
        u_cpu.wr(st, 8'h40);
        chk("irq on", 1, ovf_irq);
        wait_mode = 1;
        tk(1);
        chk("wake", 1, wake);
        u_cpu.rd(st, d);
        chk("wait rd", 8'h80, d);
        u_cpu.wr(st, 8'h20);
        wait_mode = 0;
        rc(st, 8'hc0);
        u_cpu.wr(16'h0024, 8'hff);
        u_cpu.wr(16'h0025, 8'hff);
        stop_mode = 1;
        tk(2);
        v = cnt;
        u_cpu.wr(st, 8'h20);
        tk(20);
        chk("stop", v, cnt);
        stop_mode = 0;
        tk(5);
        chk("resume", 1, cnt !== v);
        rc(st, 8'hc0);
        for (int i = 0; i < 6; i++) begin
            ev(0, i);
            rc(16'h0026 + 16'(3 * i), 8'h80);
        end
        u_cpu.wr(16'h0026, 8'hc0);
        chk("ch irq", 6'h01, ch_irq);
        u_cpu.wr(st, 8'h20);
        cap_mode = 6'h02;
        u_cpu.clr(16'h0029, 8'h00);
        ev(1, 1);
        rc(16'h0029, 8'h00);
        u_cpu.wr(st, 8'h00);
        ev(1, 1);
        rc(16'h0029, 8'h80);
        rc(16'h002f, 8'h80);
        brk = 1;
        u_cpu.clr(16'h002c, 8'h00);
        rc(16'h002c, 8'h80);
        u_cpu.wr(16'h002f, 8'h00);
        rc(16'h002f, 8'h80);
        brk = 0;
        u_cpu.wr(16'h002f, 8'h00);
        rc(16'h002f, 8'h00);
        brk = 1;
        bce = 1;
        u_cpu.clr(16'h002c, 8'h00);
        rc(16'h002c, 8'h00);
        brk = 0;
        bce = 0;
        rc(16'h002c, 8'h00);
        conclude();
    end
endmodule : tcc_core_tb
bind tcc_core tcc_core_properties u_chk (.clk, .rst_n, .ce, .bus_addr, .bus_rd, .bus_wr,
    .bus_wdata, .bus_rdata, .wait_mode, .stop_mode, .break_active, .ext_pin_force_input,
    .count_value, .ovf_irq, .ch_irq, .wake_req);
`default_nettype wire
